// ### hdl/wdg_watchdog.v
/*
 watchdog timer with interrupt mode, reset mode, protection levels and an apb register slave.
 assumes a free-running 128 kHz oscillator pin, a core that pulses restart and vector-taken
 signals in this clock domain, and a static protection fuse.
*/
`timescale 1ns/1ps
`include "wdg_defines.vh"

module wdg_watchdog #(
    parameter CNT_W = 21,
    parameter [CNT_W-1:0] BASE_CYCLES = 21'd2048
) (
    // clock and resets
    input wire core_clk_i,
    input wire rst_i,
    input wire chip_rst_i,
    // fuse and oscillator
    input wire always_on_fuse_i,
    input wire osc_128k_i,
    // core side
    input wire restart_i,
    input wire global_irq_en_i,
    input wire irq_taken_i,
    // apb slave
    input wire [7:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // events
    output reg irq_o,
    output reg wdt_reset_o
);

    // oscillator synchroniser
    reg osc_s1_reg;
    reg osc_s2_reg;
    reg osc_s3_reg;
    wire osc_tick;

    // fuse capture
    reg level2_reg;

    // control state
    reg irq_flag_reg;
    reg irq_en_reg;
    reg chg_en_reg;
    reg rst_en_reg;
    reg [3:0] psel_reg;
    reg [2:0] chg_cnt_reg;
    reg wdt_rst_flag_reg;

    // next values
    reg irq_flag_next;
    reg irq_en_next;
    reg chg_en_next;
    reg rst_en_next;
    reg [3:0] psel_next;
    reg [2:0] chg_cnt_next;
    reg wdt_rst_flag_next;
    reg wdt_reset_next;
    reg irq_next;

    // apb decode
    wire apb_setup;
    wire apb_wr;
    wire apb_rd;
    wire addr_ok;
    wire [7:0] wbyte;
    reg [31:0] rdata_next;

    // derived
    wire rst_en_eff;
    wire running;
    wire expire;
    wire counter_clear;
    wire self_reset;
    wire [3:0] wr_psel;

    // RULE_21: two flops before edge detect
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_128k_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    // RULE_01: one tick per rising oscillator edge
    assign osc_tick = osc_s2_reg & ~osc_s3_reg;

    // RULE_04: fuse caught during reset
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            level2_reg <= always_on_fuse_i;
        end
    end

    // RULE_14: level two forces enable
    // RULE_15: reset flag forces enable
    assign rst_en_eff = rst_en_reg | level2_reg | wdt_rst_flag_reg;

    // RULE_08: stopped when both enables clear
    assign running = rst_en_eff | irq_en_reg;

    assign self_reset = wdt_reset_o;

    // RULE_02: restart, disable or reset zero it
    assign counter_clear = restart_i | ~running | chip_rst_i | self_reset |
        (apb_wr && paddr_i == `WDG_OFF_RESTART);

    wdg_period_counter #(
        .CNT_W(CNT_W),
        .BASE_CYCLES(BASE_CYCLES)
    ) u_period (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i(counter_clear),
        .tick_i(osc_tick),
        .sel_i(psel_reg),
        .expire_o(expire)
    );

    // apb handshake, one wait-free access phase
    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_rd = psel_i & ~penable_i & ~pwrite_i;
    assign addr_ok = (paddr_i == `WDG_OFF_CTRL) || (paddr_i == `WDG_OFF_CAUSE) ||
        (paddr_i == `WDG_OFF_RESTART) || (paddr_i == `WDG_OFF_STATUS);
    assign wbyte = pwdata_i[7:0];
    assign wr_psel = {wbyte[`WDG_B_PSEL_HI],
        wbyte[`WDG_B_PSEL_LO_MSB:`WDG_B_PSEL_LO_LSB]};

    // control register next state
    always @* begin
        irq_flag_next = irq_flag_reg;
        irq_en_next = irq_en_reg;
        chg_en_next = chg_en_reg;
        rst_en_next = rst_en_reg;
        psel_next = psel_reg;
        chg_cnt_next = chg_cnt_reg;
        wdt_rst_flag_next = wdt_rst_flag_reg;
        wdt_reset_next = 1'b0;

        // RULE_10: window closes four cycles on
        if (chg_en_reg) begin
            if (chg_cnt_reg == `WDG_CNT3_ONE) begin
                chg_en_next = 1'b0;
                chg_cnt_next = `WDG_CNT3_ZERO;
            end else begin
                chg_cnt_next = chg_cnt_reg - `WDG_CNT3_ONE;
            end
        end

        // RULE_06: vector taken clears flag
        if (irq_taken_i) begin
            irq_flag_next = 1'b0;
        end

        if (apb_wr && paddr_i == `WDG_OFF_CTRL) begin
            // RULE_06: one written clears flag
            if (wbyte[`WDG_B_IRQ_FLAG]) begin
                irq_flag_next = 1'b0;
            end
            irq_en_next = wbyte[`WDG_B_IRQ_EN];
            // RULE_11: zero-write needs open window
            // RULE_12: disable relies on timed sequence
            if (wbyte[`WDG_B_RST_EN]) begin
                rst_en_next = 1'b1;
            end else if (chg_en_reg) begin
                rst_en_next = 1'b0;
            end
            // RULE_13: period gated by window at level two only
            // RULE_20: level two needs timed sequence
            if (!level2_reg || chg_en_reg) begin
                psel_next = wr_psel;
            end
            if (wbyte[`WDG_B_CHG_EN]) begin
                chg_en_next = 1'b1;
                chg_cnt_next = `WDG_CHG_WINDOW;
            end else begin
                chg_en_next = 1'b0;
                chg_cnt_next = `WDG_CNT3_ZERO;
            end
        end

        // RULE_18: software zero clears reset flag
        if (apb_wr && paddr_i == `WDG_OFF_CAUSE && !wbyte[`WDG_B_WDT_RST_FLAG]) begin
            wdt_rst_flag_next = 1'b0;
        end

        if (expire && running && !self_reset) begin
            if (irq_en_reg) begin
                // RULE_05: interrupt mode sets flag
                irq_flag_next = 1'b1;
                // RULE_09: reset mode drops interrupt enable
                if (rst_en_eff) begin
                    irq_en_next = 1'b0;
                end
            end else begin
                // RULE_03: time-out resets device
                wdt_reset_next = 1'b1;
            end
        end

        // RULE_18: watchdog reset sets flag
        if (self_reset) begin
            wdt_rst_flag_next = 1'b1;
        end
    end

    // RULE_07: all three conditions gate request
    always @* begin
        irq_next = irq_flag_next & irq_en_next & global_irq_en_i;
    end

    // read mux
    always @* begin
        rdata_next = 32'h0000_0000;
        case (paddr_i)
            `WDG_OFF_CTRL: begin
                rdata_next[`WDG_B_IRQ_FLAG] = irq_flag_reg;
                rdata_next[`WDG_B_IRQ_EN] = irq_en_reg;
                rdata_next[`WDG_B_PSEL_HI] = psel_reg[3];
                rdata_next[`WDG_B_CHG_EN] = chg_en_reg;
                rdata_next[`WDG_B_RST_EN] = rst_en_eff;
                rdata_next[`WDG_B_PSEL_LO_MSB:`WDG_B_PSEL_LO_LSB] = psel_reg[2:0];
            end
            `WDG_OFF_CAUSE: begin
                rdata_next[`WDG_B_WDT_RST_FLAG] = wdt_rst_flag_reg;
            end
            `WDG_OFF_STATUS: begin
                rdata_next[`WDG_B_ST_RUNNING] = running;
                rdata_next[`WDG_B_ST_LEVEL2] = level2_reg;
                rdata_next[`WDG_B_ST_WINDOW] = chg_en_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // control and reset-flag registers
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            // RULE_18: power-on clears reset flag
            wdt_rst_flag_reg <= 1'b0;
        end else begin
            wdt_rst_flag_reg <= wdt_rst_flag_next;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i || chip_rst_i || self_reset) begin
            irq_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            chg_en_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            psel_reg <= `WDG_PSEL_RESET;
            chg_cnt_reg <= `WDG_CNT3_ZERO;
            irq_o <= 1'b0;
        end else begin
            irq_flag_reg <= irq_flag_next;
            irq_en_reg <= irq_en_next;
            chg_en_reg <= chg_en_next;
            rst_en_reg <= rst_en_next;
            psel_reg <= psel_next;
            chg_cnt_reg <= chg_cnt_next;
            irq_o <= irq_next;
        end
    end

    // RULE_19: one-cycle reset pulse
    always @(posedge core_clk_i) begin
        if (rst_i || chip_rst_i) begin
            wdt_reset_o <= 1'b0;
        end else begin
            wdt_reset_o <= wdt_reset_next;
        end
    end

    // apb answer registers
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup & ~addr_ok;
            if (apb_rd) begin
                prdata_o <= rdata_next;
            end else if (apb_setup) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

endmodule

// ### hdl/wdg_defines.vh
/*
 constants of the watchdog timer: register offsets, field positions, reset values, timings.
 assumes inclusion by bare name from the watchdog design files only.
*/
// Contract
// RULE_01: counter advances on 128 kHz oscillator ticks
// RULE_02: restart, disable, chip reset zero the counter
// RULE_03: reset-only time-out resets the device
// RULE_04: fuse selects protection level one or two
// RULE_05: time-out in interrupt mode sets flag
// RULE_06: flag cleared by vector taken or one-write
// RULE_07: interrupt needs flag, enable, global enable
// RULE_08: enable pair decides interrupt, reset, or stop
// RULE_09: time-out clears interrupt enable when reset enabled
// RULE_10: change enable self-clears four cycles later
// RULE_11: reset enable zero-write needs change enable
// RULE_12: software disables with timed two-write sequence
// RULE_13: period changes need open change window (code gates them at level two only)
// RULE_14: level two keeps timer always enabled
// RULE_15: level one forces enable while reset flag set
// RULE_16: four-bit period field, ten doubling periods
// RULE_17: unused watchdog: firmware clears flag and enable
// RULE_18: reset flag set by watchdog, cleared otherwise
// RULE_19: watchdog reset pulse lasts one clock
// RULE_20: level two period change uses timed sequence
// RULE_21: oscillator events cross safely into clock domain
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

// register byte offsets
`define WDG_OFF_CTRL 8'h00
`define WDG_OFF_CAUSE 8'h04
`define WDG_OFF_RESTART 8'h08
`define WDG_OFF_STATUS 8'h0c

// control register fields
`define WDG_B_IRQ_FLAG 7
`define WDG_B_IRQ_EN 6
`define WDG_B_PSEL_HI 5
`define WDG_B_CHG_EN 4
`define WDG_B_RST_EN 3
`define WDG_B_PSEL_LO_MSB 2
`define WDG_B_PSEL_LO_LSB 0

// reset-cause register field
`define WDG_B_WDT_RST_FLAG 3

// status register fields
`define WDG_B_ST_RUNNING 0
`define WDG_B_ST_LEVEL2 1
`define WDG_B_ST_WINDOW 2

// period select
`define WDG_PSEL_RESET 4'h0
`define WDG_PSEL_MAX 4'h9

// oscillator rate and change window
`define WDG_OSC_KHZ 128
`define WDG_CHG_WINDOW 3'h4
`define WDG_CNT3_ZERO 3'h0
`define WDG_CNT3_ONE 3'h1

`endif

// ### hdl/wdg_period_counter.v
/*
 watchdog period counter: counts oscillator ticks and flags expiry of the selected period.
 assumes a one-cycle tick per rising oscillator edge from the same clock domain.
*/
`timescale 1ns/1ps
`include "wdg_defines.vh"

module wdg_period_counter #(
    parameter CNT_W = 21,
    parameter [CNT_W-1:0] BASE_CYCLES = 21'd2048
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // control
    input wire clear_i,
    input wire tick_i,
    input wire [3:0] sel_i,
    // expiry
    output reg expire_o
);

    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] count_next;
    reg expire_next;
    reg [3:0] sel_eff;
    reg [CNT_W-1:0] limit;

    // RULE_16: doubling periods, reserved codes saturate
    always @* begin
        sel_eff = (sel_i > `WDG_PSEL_MAX) ? `WDG_PSEL_MAX : sel_i;
        limit = BASE_CYCLES << sel_eff;
        count_next = count_reg;
        expire_next = 1'b0;
        if (clear_i) begin
            count_next = {CNT_W{1'b0}};
        end else if (tick_i) begin
            if (count_reg >= limit - 1'b1) begin
                count_next = {CNT_W{1'b0}};
                expire_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            count_reg <= {CNT_W{1'b0}};
            expire_o <= 1'b0;
        end else begin
            count_reg <= count_next;
            expire_o <= expire_next;
        end
    end

endmodule

// ### tb/wdg_core_model.sv
/* core and oscillator stand-in at the far side of the watchdog.
   assumes the bench steers global enable and periodic restarts. */
`timescale 1ns/1ps
module wdg_core_model (
    // clock
    input wire core_clk_i,
    // bench controls
    input wire gie_i,
    input wire kick_i,
    // watchdog side
    input wire irq_i,
    output logic osc_o,
    output logic restart_o,
    output logic gie_o,
    output logic taken_o
);
    logic [3:0] div = 4'h0;
    always @(posedge core_clk_i) begin
        div <= div + 4'h1;
        osc_o <= div[2];
        restart_o <= kick_i && (div == 4'hf);
        gie_o <= gie_i;
        taken_o <= irq_i && !taken_o;
    end
endmodule

// ### tb/wdg_checker.sv
/* checker on the watchdog ports.
   assumes one clock domain, bound into wdg_watchdog. */
`timescale 1ns/1ps
module wdg_checker (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // inputs
    input wire always_on_fuse_i,
    input wire global_irq_en_i,
    input wire irq_taken_i,
    input wire [7:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    // outputs
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire irq_o,
    input wire wdt_reset_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_done;
        psel_i && penable_i && pready_o;
    endsequence
    property p_answer;
        s_setup |=> s_done;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    property p_ready_short;
        pready_o |=> !pready_o;
    endproperty
    a_ready_short: assert property (p_ready_short) else $error("ready too long");
    property p_err_ready;
        pslverr_o |-> pready_o && psel_i;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_unmapped;
        s_setup ##0 (paddr_i[1:0] != 2'h0 || paddr_i > 8'h0c) |=> pslverr_o;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_pulse;
        wdt_reset_o |=> !wdt_reset_o [*4];
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_gie;
        irq_o |-> $past(global_irq_en_i);
    endproperty
    a_gie: assert property (p_gie) else $error("irq without global enable");
    property p_taken;
        irq_taken_i |-> ##2 !irq_o;
    endproperty
    a_taken: assert property (p_taken) else $error("irq kept after taken");
    property p_level2;
        s_done ##0 (!pwrite_i && paddr_i == 8'h00 && always_on_fuse_i) |-> prdata_o[3];
    endproperty
    a_level2: assert property (p_level2) else $error("enable not forced");
endmodule
bind wdg_watchdog wdg_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .always_on_fuse_i(always_on_fuse_i), .global_irq_en_i(global_irq_en_i),
    .irq_taken_i(irq_taken_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));

// ### tb/tb.sv
/* self-checking bench of the watchdog over apb.
   assumes a shortened base period of 4 ticks. */
`timescale 1ns/1ps
module tb;
    logic core_clk_i, rst_i, chip_rst_i, always_on_fuse_i, osc, restart, gie, taken;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, wdt_reset_o;
    logic er, gie_req, kick;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    int error_cnt, num_checks, cyc, c;
    logic [3:0] row_sel [4] = '{4'h0, 4'h1, 4'h9, 4'hf};
    int row_tk [4] = '{4, 8, 2048, 2048};
    wdg_watchdog #(.BASE_CYCLES(21'd4)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .chip_rst_i(chip_rst_i), .always_on_fuse_i(always_on_fuse_i), .osc_128k_i(osc),
        .restart_i(restart), .global_irq_en_i(gie), .irq_taken_i(taken),
        .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));
    wdg_core_model u_core (.core_clk_i(core_clk_i), .gie_i(gie_req), .kick_i(kick),
        .irq_i(irq_o), .osc_o(osc), .restart_o(restart), .gie_o(gie), .taken_o(taken));
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask
    task automatic wait_ev(input int lim);
        c = 0;
        do begin
            @(posedge core_clk_i);
            c++;
        end while (irq_o !== 1'b1 && wdt_reset_o !== 1'b1 && c < lim);
    endtask
    task automatic do_reset(input logic f);
        always_on_fuse_i <= f;
        rst_i <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
    endtask
    initial begin
        {rst_i, chip_rst_i, always_on_fuse_i, psel_i, penable_i, pwrite_i} = 6'h20;
        {gie_req, kick, paddr_i, pwdata_i} = '0;
        {error_cnt, num_checks} = '0;
        do_reset(1'b0);
        rchk(8'h00, 8'h00, "ctrl");
        rchk(8'h04, 8'h00, "cause");
        apb(1'b0, 8'h10, 8'h00);
        chk("slverr", 32'h1, {31'h0, er});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, {2'b00, row_sel[i][3], 2'b01, row_sel[i][2:0]});
            wait_ev(20000);
            chk_rng("period", row_tk[i] * 8 - 8, row_tk[i] * 8 + 16, c);
            chk("rst", 32'h1, {31'h0, wdt_reset_o});
            rchk(8'h04, 8'h08, "cause");
            rchk(8'h00, 8'h08, "ctrl");
            apb(1'b1, 8'h04, 8'h00);
            rchk(8'h00, 8'h00, "ctrl");
        end
        apb(1'b1, 8'h00, 8'h48);
        repeat (38) @(posedge core_clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        rchk(8'h00, 8'h88, "ctrl");
        apb(1'b1, 8'h00, 8'h88);
        rchk(8'h00, 8'h08, "ctrl");
        wait_ev(60);
        chk("rst", 32'h1, {31'h0, wdt_reset_o});
        apb(1'b1, 8'h04, 8'h00);
        apb(1'b1, 8'h00, 8'h40);
        repeat (38) @(posedge core_clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        gie_req <= 1'b1;
        wait_ev(60);
        chk("irq", 32'h1, {31'h0, irq_o});
        apb(1'b1, 8'h08, 8'h00);
        repeat (4) @(posedge core_clk_i);
        rchk(8'h00, 8'h40, "ctrl");
        apb(1'b1, 8'h00, 8'h08);
        apb(1'b1, 8'h00, 8'h00);
        rchk(8'h00, 8'h08, "ctrl");
        apb(1'b1, 8'h00, 8'h18);
        apb(1'b1, 8'h00, 8'h00);
        rchk(8'h00, 8'h00, "ctrl");
        apb(1'b1, 8'h00, 8'h18);
        repeat (6) @(posedge core_clk_i);
        apb(1'b1, 8'h00, 8'h00);
        rchk(8'h00, 8'h08, "ctrl");
        kick <= 1'b1;
        do_reset(1'b1);
        rchk(8'h00, 8'h08, "ctrl");
        apb(1'b1, 8'h00, 8'h18);
        apb(1'b1, 8'h00, 8'h00);
        rchk(8'h00, 8'h08, "ctrl");
        apb(1'b1, 8'h00, 8'h01);
        rchk(8'h00, 8'h08, "ctrl");
        apb(1'b1, 8'h00, 8'h18);
        apb(1'b1, 8'h00, 8'h01);
        rchk(8'h00, 8'h09, "ctrl");
        rchk(8'h0c, 8'h03, "status");
        wait_ev(300);
        chk_rng("kick", 300, 300, c);
        kick <= 1'b0;
        repeat (30) apb(1'b1, 8'h08, 8'h00);
        rchk(8'h04, 8'h00, "cause");
        wait_ev(400);
        chk_rng("expiry", 40, 90, c);
        rchk(8'h04, 8'h08, "cause");
        chip_rst_i <= 1'b1;
        @(posedge core_clk_i);
        chip_rst_i <= 1'b0;
        rchk(8'h00, 8'h08, "ctrl");
        rchk(8'h04, 8'h08, "cause");
        report_and_stop;
    end
endmodule
